// ### pkg/pfbu_pkg.sv
package pfbu_pkg;

  // Instruction classes handled by the flow unit
  typedef enum logic [4:0] {
    PFBU_OP_NOP      = 5'h00,
    PFBU_OP_JMP_IDX  = 5'h01,
    PFBU_OP_JMP_EXT  = 5'h02,
    PFBU_OP_BR_REL   = 5'h03,
    PFBU_OP_CALL_REL = 5'h04,
    PFBU_OP_CALL_IDX = 5'h05,
    PFBU_OP_CALL_EXT = 5'h06,
    PFBU_OP_RET_SUB  = 5'h07,
    PFBU_OP_TRAP     = 5'h08,
    PFBU_OP_RET_INT  = 5'h09,
    PFBU_OP_IDLE     = 5'h0a,
    PFBU_OP_BCOND    = 5'h0b
  } pfbu_op_t;

  // Branch condition selectors
  typedef enum logic [3:0] {
    PFBU_CC_NEG  = 4'h0, PFBU_CC_POS  = 4'h1,
    PFBU_CC_ZERO = 4'h2, PFBU_CC_NZ   = 4'h3,
    PFBU_CC_OVF  = 4'h4, PFBU_CC_NOVF = 4'h5,
    PFBU_CC_CRY  = 4'h6, PFBU_CC_NCRY = 4'h7,
    PFBU_CC_HI   = 4'h8, PFBU_CC_LS   = 4'h9,
    PFBU_CC_LT   = 4'ha, PFBU_CC_GE   = 4'hb,
    PFBU_CC_LE   = 4'hc, PFBU_CC_GT   = 4'hd
  } pfbu_cc_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } pfbu_flags_t;

  // Instruction request from the fetch/decode front end
  typedef struct packed {
    pfbu_op_t    op;
    pfbu_cc_t    cc;
    logic [15:0] pc;
    logic [7:0]  b1;
    logic [7:0]  b2;
  } pfbu_req_t;

  // Processor state that an interrupt-style push saves
  typedef struct packed {
    logic [7:0] ccr;
    logic [7:0] acc_b;
    logic [7:0] acc_a;
    logic [15:0] idx;
  } pfbu_regs_t;

  typedef enum logic [2:0] {
    PFBU_ST_IDLE = 3'h0,
    PFBU_ST_PUSH = 3'h1,
    PFBU_ST_PULL = 3'h2,
    PFBU_ST_VEC  = 3'h3,
    PFBU_ST_WAIT = 3'h4,
    PFBU_ST_DONE = 3'h5
  } pfbu_state_t;

  localparam logic [15:0] PFBU_TRAP_VEC_HI = 16'hfffa;
  localparam logic [15:0] PFBU_TRAP_VEC_LO = 16'hfffb;
  localparam logic [15:0] PFBU_PC_RESET    = 16'h0000;
  localparam logic [15:0] PFBU_SP_RESET    = 16'h0000;
  localparam logic [15:0] PFBU_LEN_ONE     = 16'h0001;
  localparam logic [15:0] PFBU_LEN_TWO     = 16'h0002;
  localparam logic [15:0] PFBU_LEN_THREE   = 16'h0003;
  localparam logic [3:0]  PFBU_RET_BYTES   = 4'h2;
  localparam logic [3:0]  PFBU_INT_BYTES   = 4'h7;
  // Extra execute cycles, relative forms against absolute forms
  localparam logic [3:0]  PFBU_EXT_JMP_CYC  = 4'h1;
  localparam logic [3:0]  PFBU_REL_JMP_CYC  = 4'h2;
  localparam logic [3:0]  PFBU_EXT_CALL_CYC = 4'h3;
  localparam logic [3:0]  PFBU_REL_CALL_CYC = 4'h2;

endpackage : pfbu_pkg

// ### design/pfbu_cond.sv
`timescale 1ns/10ps
module pfbu_cond (
  input  wire pfbu_pkg::pfbu_cc_t    i_cc,
  input  wire pfbu_pkg::pfbu_flags_t i_flags,
  output logic                       o_taken
);
  wire nxv = i_flags.n ^ i_flags.v;
  wire cz  = i_flags.c | i_flags.z;
  wire zn  = i_flags.z | nxv;

  always_comb begin
    case (i_cc)
      pfbu_pkg::PFBU_CC_NEG:  o_taken = i_flags.n;
      pfbu_pkg::PFBU_CC_POS:  o_taken = ~i_flags.n;
      pfbu_pkg::PFBU_CC_ZERO: o_taken = i_flags.z;
      pfbu_pkg::PFBU_CC_NZ:   o_taken = ~i_flags.z;
      pfbu_pkg::PFBU_CC_OVF:  o_taken = i_flags.v;
      pfbu_pkg::PFBU_CC_NOVF: o_taken = ~i_flags.v;
      pfbu_pkg::PFBU_CC_CRY:  o_taken = i_flags.c;
      pfbu_pkg::PFBU_CC_NCRY: o_taken = ~i_flags.c;
      pfbu_pkg::PFBU_CC_HI:   o_taken = ~cz;
      pfbu_pkg::PFBU_CC_LS:   o_taken = cz;
      pfbu_pkg::PFBU_CC_LT:   o_taken = nxv;
      pfbu_pkg::PFBU_CC_GE:   o_taken = ~nxv;
      pfbu_pkg::PFBU_CC_LE:   o_taken = zn;
      pfbu_pkg::PFBU_CC_GT:   o_taken = ~zn;
      default:                o_taken = 1'b0;
    endcase
  end
endmodule : pfbu_cond

// ### design/pfbu_flow.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
// How it works
// - No-operation only advances the program counter by one.
// - Indexed jump goes to index register plus offset byte.
// - Extended jump goes to the two bytes after the opcode.
// - Relative jump reaches -126..+129 bytes from its own location.
// - Relative jump is one byte shorter, one cycle slower than extended jump.
// - Calls advance the program counter past the call before pushing it.
// - Relative call is 2 bytes, extended call 3; relative one cycle faster.
// - Subroutine return resumes at the caller's saved return point.
// - Trap stacks registers, then loads PC from vector bytes FFFA, FFFB.
// - Trap saves the address of the instruction after it.
// - Interrupt return restores stacked state and resumes the program.
// - Idle pushes state first, waits for interrupt; response skips stacking.
// - Conditional branch falls through on fail, goes relative on success.
// - Simple branches test one of N, Z, V, C set or clear.
// - Higher needs C and Z clear; lower-or-same needs either set.
// - Signed less when N xor V is one; signed ge when zero.
// - Signed le when Z or N xor V; signed greater when neither.
// - Trap and idle push all registers but the stack pointer; an interrupt is taken only after idle and pushes nothing.
// - Stack pointer decrements after each pushed byte.
// - Subroutine return pulls the return address into the program counter.
module pfbu_flow (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ce,
  input  wire logic                  i_req_valid,
  input  wire pfbu_pkg::pfbu_req_t   i_req,
  input  wire pfbu_pkg::pfbu_flags_t i_flags,
  input  wire pfbu_pkg::pfbu_regs_t  i_regs,
  input  wire logic                  i_irq,
  input  wire logic [15:0]           i_irq_vector,
  input  wire logic [7:0]            i_mem_rdata,
  output logic                       o_busy,
  output logic                       o_done,
  output logic [15:0]                o_next_pc,
  output logic                       o_taken,
  output logic                       o_regs_valid,
  output pfbu_pkg::pfbu_regs_t       o_regs,
  output logic                       o_mem_we,
  output logic                       o_mem_re,
  output logic [15:0]                o_mem_addr,
  output logic [7:0]                 o_mem_wdata,
  output logic [15:0]                o_sp,
  output logic                       o_waiting
);
  pfbu_pkg::pfbu_state_t state_q, state_d;
  logic [15:0] sp_q, pc_q, tgt_q, vec_q;
  logic [3:0]  cnt_q, delay_q;
  logic        is_int_q, is_trap_q, taken_q, prestacked_q, is_pull_q;
  logic [55:0] frame_q;
  logic [7:0]  pull_q [0:6];

  wire cond_taken;
  wire [15:0] ext_addr  = {i_req.b1, i_req.b2};
  wire [15:0] rel_next  = i_req.pc + pfbu_pkg::PFBU_LEN_TWO;
  wire [15:0] rel_tgt   = rel_next + {{8{i_req.b1[7]}}, i_req.b1};
  wire [15:0] idx_tgt   = i_regs.idx + {8'h00, i_req.b1};
  wire        start     = i_ce & i_req_valid & (state_q == pfbu_pkg::PFBU_ST_IDLE);
  wire [55:0] int_frame;

  pfbu_cond u_cond (
    .i_cc    (i_req.cc),
    .i_flags (i_flags),
    .o_taken (cond_taken)
  );

  // Interrupt frame, pushed low byte of PC first so pulls run in reverse
  function automatic logic [55:0] pfbu_frame(input logic [15:0] ret,
                                             input pfbu_pkg::pfbu_regs_t r);
    pfbu_frame = {r.ccr, r.acc_b, r.acc_a, r.idx, ret};
  endfunction : pfbu_frame

  wire [15:0] next_seq =
    (i_req.op == pfbu_pkg::PFBU_OP_NOP)      ? i_req.pc + pfbu_pkg::PFBU_LEN_ONE :
    (i_req.op == pfbu_pkg::PFBU_OP_TRAP)     ? i_req.pc + pfbu_pkg::PFBU_LEN_ONE :
    (i_req.op == pfbu_pkg::PFBU_OP_IDLE)     ? i_req.pc + pfbu_pkg::PFBU_LEN_ONE :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_EXT) ? i_req.pc + pfbu_pkg::PFBU_LEN_THREE :
    rel_next;
  assign int_frame = pfbu_frame(next_seq, i_regs);

  wire [15:0] dest =
    (i_req.op == pfbu_pkg::PFBU_OP_JMP_IDX)  ? idx_tgt :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_IDX) ? idx_tgt :
    (i_req.op == pfbu_pkg::PFBU_OP_JMP_EXT)  ? ext_addr :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_EXT) ? ext_addr :
    (i_req.op == pfbu_pkg::PFBU_OP_BR_REL)   ? rel_tgt :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_REL) ? rel_tgt :
    (i_req.op == pfbu_pkg::PFBU_OP_BCOND)    ? (cond_taken ? rel_tgt : rel_next) :
    next_seq;

  wire [3:0] delay_for =
    (i_req.op == pfbu_pkg::PFBU_OP_JMP_EXT)  ? pfbu_pkg::PFBU_EXT_JMP_CYC :
    (i_req.op == pfbu_pkg::PFBU_OP_BR_REL)   ? pfbu_pkg::PFBU_REL_JMP_CYC :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_EXT) ? pfbu_pkg::PFBU_EXT_CALL_CYC :
    (i_req.op == pfbu_pkg::PFBU_OP_CALL_REL) ? pfbu_pkg::PFBU_REL_CALL_CYC :
    pfbu_pkg::PFBU_EXT_JMP_CYC;

  wire op_call = (i_req.op == pfbu_pkg::PFBU_OP_CALL_REL) |
                 (i_req.op == pfbu_pkg::PFBU_OP_CALL_IDX) |
                 (i_req.op == pfbu_pkg::PFBU_OP_CALL_EXT);
  wire op_int  = (i_req.op == pfbu_pkg::PFBU_OP_TRAP) | (i_req.op == pfbu_pkg::PFBU_OP_IDLE);
  wire op_pull = (i_req.op == pfbu_pkg::PFBU_OP_RET_SUB) |
                 (i_req.op == pfbu_pkg::PFBU_OP_RET_INT);
  wire [3:0] nbytes = is_int_q ? pfbu_pkg::PFBU_INT_BYTES : pfbu_pkg::PFBU_RET_BYTES;
  wire last  = (cnt_q == nbytes - 4'h1);
  wire [2:0] byte_sel = cnt_q[2:0];
  wire [7:0] push_byte = frame_q[{byte_sel, 3'b000} +: 8];
  wire [15:0] sp_inc = sp_q + pfbu_pkg::PFBU_LEN_ONE;

  // Pulled return address ends the pull stream (high byte then low byte)
  wire [2:0]  hi_i     = is_int_q ? 3'h5 : 3'h0;
  wire [2:0]  lo_i     = is_int_q ? 3'h6 : 3'h1;
  wire [15:0] ret_addr = {pull_q[hi_i], pull_q[lo_i]};
  // Returns take the stacked address, everything else the latched target
  wire [15:0] done_pc  = is_pull_q ? ret_addr : tgt_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pfbu_pkg::PFBU_ST_IDLE: begin
        if (start) begin
          if (op_call | op_int)
            state_d = pfbu_pkg::PFBU_ST_PUSH;
          else if (op_pull)
            state_d = pfbu_pkg::PFBU_ST_PULL;
          else
            state_d = pfbu_pkg::PFBU_ST_DONE;
        end else if (i_ce & i_irq & prestacked_q) begin
          state_d = pfbu_pkg::PFBU_ST_DONE;
        end
      end
      pfbu_pkg::PFBU_ST_PUSH: begin
        if (last)
          state_d = is_trap_q ? pfbu_pkg::PFBU_ST_VEC :
                    is_int_q ? pfbu_pkg::PFBU_ST_WAIT : pfbu_pkg::PFBU_ST_DONE;
      end
      pfbu_pkg::PFBU_ST_PULL: if (last) state_d = pfbu_pkg::PFBU_ST_DONE;
      pfbu_pkg::PFBU_ST_VEC:  if (cnt_q[0]) state_d = pfbu_pkg::PFBU_ST_DONE;
      pfbu_pkg::PFBU_ST_WAIT: state_d = pfbu_pkg::PFBU_ST_IDLE;
      pfbu_pkg::PFBU_ST_DONE: if (delay_q == 4'h0) state_d = pfbu_pkg::PFBU_ST_IDLE;
      default:                state_d = pfbu_pkg::PFBU_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q      <= pfbu_pkg::PFBU_ST_IDLE;
      sp_q         <= pfbu_pkg::PFBU_SP_RESET;
      pc_q         <= pfbu_pkg::PFBU_PC_RESET;
      tgt_q        <= pfbu_pkg::PFBU_PC_RESET;
      vec_q        <= pfbu_pkg::PFBU_PC_RESET;
      cnt_q        <= 4'h0;
      delay_q      <= 4'h0;
      is_int_q     <= 1'b0;
      is_trap_q    <= 1'b0;
      taken_q      <= 1'b0;
      prestacked_q <= 1'b0;
      is_pull_q    <= 1'b0;
      frame_q      <= 56'h0;
    end else if (i_ce) begin
      state_q <= state_d;
      if (start) begin
        tgt_q     <= dest;
        is_int_q  <= op_int | (i_req.op == pfbu_pkg::PFBU_OP_RET_INT);
        is_trap_q <= (i_req.op == pfbu_pkg::PFBU_OP_TRAP);
        is_pull_q <= op_pull;
        taken_q   <= (i_req.op == pfbu_pkg::PFBU_OP_BCOND) ? cond_taken :
                     (i_req.op != pfbu_pkg::PFBU_OP_NOP);
        frame_q   <= int_frame;
        cnt_q     <= 4'h0;
        delay_q   <= op_pull ? 4'h0 : delay_for - 4'h1;
      end else if (state_q == pfbu_pkg::PFBU_ST_IDLE && i_irq && prestacked_q) begin
        prestacked_q <= 1'b0;
        tgt_q        <= i_irq_vector;
        taken_q      <= 1'b1;
        delay_q      <= 4'h0;
      end
      if (state_q == pfbu_pkg::PFBU_ST_PUSH) begin
        sp_q  <= sp_q - pfbu_pkg::PFBU_LEN_ONE;
        cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
      end
      if (state_q == pfbu_pkg::PFBU_ST_PULL) begin
        sp_q  <= sp_inc;
        cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
      end
      if (state_q == pfbu_pkg::PFBU_ST_VEC) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q[0])
          tgt_q <= {vec_q[7:0], i_mem_rdata};
      end
      if (state_q == pfbu_pkg::PFBU_ST_VEC && !cnt_q[0])
        vec_q <= {8'h00, i_mem_rdata};
      if (state_q == pfbu_pkg::PFBU_ST_WAIT)
        prestacked_q <= 1'b1;
      if (state_q == pfbu_pkg::PFBU_ST_DONE) begin
        pc_q    <= done_pc;
        delay_q <= delay_q - 4'h1;
      end
    end
  end

  // Pulled bytes land in order: last-pushed first
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pull
      always_ff @(posedge i_clock) begin
        if (!i_rst_b)
          pull_q[gi] <= 8'h00;
        else if (i_ce && state_q == pfbu_pkg::PFBU_ST_PULL && cnt_q == 4'(gi))
          pull_q[gi] <= i_mem_rdata;
      end
    end
  endgenerate

  // Memory requests are combinational so data return the same cycle
  assign o_mem_we    = i_ce & (state_q == pfbu_pkg::PFBU_ST_PUSH);
  assign o_mem_re    = i_ce & ((state_q == pfbu_pkg::PFBU_ST_PULL) |
                               (state_q == pfbu_pkg::PFBU_ST_VEC));
  assign o_mem_addr  = (state_q == pfbu_pkg::PFBU_ST_PUSH) ? sp_q :
                       (state_q == pfbu_pkg::PFBU_ST_PULL) ? sp_inc :
                       cnt_q[0] ? pfbu_pkg::PFBU_TRAP_VEC_LO : pfbu_pkg::PFBU_TRAP_VEC_HI;
  assign o_mem_wdata = push_byte;

  // The new address shows in the done cycle itself, then stays in pc_q
  assign o_next_pc    = (state_q == pfbu_pkg::PFBU_ST_DONE) ? done_pc : pc_q;
  assign o_busy       = (state_q != pfbu_pkg::PFBU_ST_IDLE);
  assign o_done       = i_ce & (state_q == pfbu_pkg::PFBU_ST_DONE) & (delay_q == 4'h0);
  assign o_taken      = taken_q;
  assign o_sp         = sp_q;
  assign o_waiting    = prestacked_q;
  assign o_regs_valid = o_done & is_int_q & is_pull_q;
  assign o_regs       = '{ccr: pull_q[0], acc_b: pull_q[1], acc_a: pull_q[2],
                          idx: {pull_q[3], pull_q[4]}};
endmodule : pfbu_flow

// ### verif/pfbu_flow_assertions.sv
`timescale 1ns/10ps
module pfbu_flow_assertions (
  input wire logic                 i_clock,
  input wire logic                 i_rst_b,
  input wire logic                 i_ce,
  input wire logic                 i_req_valid,
  input wire pfbu_pkg::pfbu_req_t  i_req,
  input wire pfbu_pkg::pfbu_regs_t i_regs,
  input wire logic [7:0]           i_mem_rdata,
  input wire logic                 o_busy,
  input wire logic                 o_done,
  input wire logic [15:0]          o_next_pc,
  input wire logic                 o_taken,
  input wire logic                 o_mem_we,
  input wire logic                 o_mem_re,
  input wire logic [15:0]          o_mem_addr,
  input wire logic [15:0]          o_sp,
  input wire logic                 o_waiting
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  pfbu_pkg::pfbu_req_t r_q;
  logic [15:0]         x_q;
  logic [15:0]         v_q;
  wire                 take = i_ce && i_req_valid && !o_busy;
  wire [15:0]          rel  = r_q.pc + 16'h0002 + {{8{r_q.b1[7]}}, r_q.b1};

  // Vector bytes are caught as read, so the check holds whatever memory holds
  always_ff @(posedge i_clock) begin
    if (take) begin
      r_q <= i_req;
      x_q <= i_regs.idx;
    end
    if (o_mem_re && o_mem_addr == pfbu_pkg::PFBU_TRAP_VEC_HI) begin
      v_q[15:8] <= i_mem_rdata;
    end
    if (o_mem_re && o_mem_addr == pfbu_pkg::PFBU_TRAP_VEC_LO) begin
      v_q[7:0] <= i_mem_rdata;
    end
  end

  property p_pc(pfbu_pkg::pfbu_op_t op, logic [15:0] exp);
    o_done && r_q.op == op |-> o_next_pc == exp;
  endproperty
  sequence s_push;
    o_mem_we && o_mem_addr == o_sp;
  endsequence

  chk_nop_advance: assert property (p_pc(pfbu_pkg::PFBU_OP_NOP, r_q.pc + 16'h0001))
    else $error("nop target");
  chk_jump_index: assert property (p_pc(pfbu_pkg::PFBU_OP_JMP_IDX, x_q + {8'h00, r_q.b1}))
    else $error("indexed jump target");
  chk_jump_ext: assert property (p_pc(pfbu_pkg::PFBU_OP_JMP_EXT, {r_q.b1, r_q.b2}))
    else $error("extended jump target");
  chk_rel_target: assert property (p_pc(pfbu_pkg::PFBU_OP_BR_REL, rel))
    else $error("relative jump target");
  chk_trap_vector: assert property (p_pc(pfbu_pkg::PFBU_OP_TRAP, v_q))
    else $error("trap vector");
  chk_cond_target: assert property (
    o_done && r_q.op == pfbu_pkg::PFBU_OP_BCOND
      |-> o_next_pc == (o_taken ? rel : r_q.pc + 16'h0002))
    else $error("branch target");
  chk_push_step: assert property (o_mem_we |-> s_push ##1 o_sp == $past(o_sp) - 16'h0001)
    else $error("stack push step");
  chk_idle_quiet: assert property (o_waiting |-> !o_mem_we)
    else $error("write while waiting");
endmodule : pfbu_flow_assertions

// ### verif/pfbu_mem_model.sv
`timescale 1ns/10ps
module pfbu_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;

  // Idle read data shows the inverse of the last byte, never a stale copy
  assign o_rdata = i_re ? mem[i_addr] : ~last_q;
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_re) begin
      last_q <= o_rdata;
    end
  end
endmodule : pfbu_mem_model

// ### verif/pfbu_flow_test.sv
`timescale 1ns/10ps
module pfbu_flow_test;
  logic                  i_clock, i_rst_b, i_ce, i_req_valid, i_irq;
  pfbu_pkg::pfbu_req_t   i_req;
  pfbu_pkg::pfbu_flags_t i_flags;
  pfbu_pkg::pfbu_regs_t  i_regs, o_regs, got;
  logic [15:0]           i_irq_vector, o_next_pc, o_mem_addr, o_sp, sp_e;
  logic [7:0]            i_mem_rdata, o_mem_wdata;
  logic                  o_busy, o_done, o_taken, o_regs_valid, o_mem_we, o_mem_re, o_waiting;
  logic [15:0]           ret_a [4];
  int                    mismatches, n_compared, cyc, n_we, w0, ticks;

  pfbu_flow i_dut (
    .i_clock, .i_rst_b, .i_ce, .i_req_valid, .i_req, .i_flags, .i_regs, .i_irq,
    .i_irq_vector, .i_mem_rdata, .o_busy, .o_done, .o_next_pc, .o_taken, .o_regs_valid,
    .o_regs, .o_mem_we, .o_mem_re, .o_mem_addr, .o_mem_wdata, .o_sp, .o_waiting
  );
  pfbu_mem_model i_mem (
    .i_clock, .i_we(o_mem_we), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata)
  );

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(negedge i_clock) begin
    if (o_mem_we === 1'b1) n_we++;
  end
  always @(posedge i_clock) begin
    ticks++;
    if (ticks == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic cond(input logic [3:0] c, input pfbu_pkg::pfbu_flags_t f);
    logic [6:0] t;
    t = {f.z | (f.n ^ f.v), f.n ^ f.v, ~(f.c | f.z), f.c, f.v, f.z, f.n};
    return t[c[3:1]] ^ c[0];
  endfunction : cond

  // Raises the interrupt only once the unit reports it has prestacked
  task automatic run(input pfbu_pkg::pfbu_op_t op, input logic [3:0] cc,
                     input logic [15:0] pc, input logic [7:0] b1, input logic [7:0] b2);
    @(negedge i_clock);
    while (o_busy !== 1'b0) @(negedge i_clock);
    @(posedge i_clock);
    i_req_valid <= 1'b1;
    i_req <= {op, cc, pc, b1, b2};
    @(posedge i_clock);
    i_req_valid <= 1'b0;
    cyc = 0;
    do begin
      @(negedge i_clock);
      cyc++;
      if (o_waiting === 1'b1 && !i_irq) begin
        w0 = n_we;
        i_irq <= 1'b1;
      end
      if (o_regs_valid === 1'b1) got = o_regs;
    end while (o_done !== 1'b1 && cyc < 60);
    i_irq <= 1'b0;
    if (cyc >= 60) mismatches++;
  endtask : run

  task automatic t_jumps;
    int ce;
    run(pfbu_pkg::PFBU_OP_NOP, 4'h0, 16'h1234, 8'h00, 8'h00);
    check(o_next_pc, 16'h1235);
    run(pfbu_pkg::PFBU_OP_JMP_IDX, 4'h0, 16'h1000, 8'h7f, 8'h00);
    check(o_next_pc, 16'h207f);
    run(pfbu_pkg::PFBU_OP_JMP_EXT, 4'h0, 16'h1000, 8'hab, 8'hcd);
    check(o_next_pc, 16'habcd);
    ce = cyc;
    run(pfbu_pkg::PFBU_OP_BR_REL, 4'h0, 16'h4000, 8'h81, 8'h00);
    check(o_next_pc, 16'h3f83);
    check(cyc, ce + 1);
    run(pfbu_pkg::PFBU_OP_BR_REL, 4'h0, 16'h4000, 8'h7d, 8'h00);
    check(o_next_pc, 16'h407f);
  endtask : t_jumps

  // Four nested calls push down past the trap vector bytes on purpose
  task automatic t_calls;
    logic [15:0] pc [4] = '{16'h0100, 16'h1234, 16'hc310, 16'h2058};
    logic [15:0] tg [4] = '{16'h1234, 16'h1246, 16'h2000, 16'h204a};
    logic [15:0] d;
    int          ce;
    for (int i = 0; i < 4; i++) begin
      ret_a[i] = pc[i] + (i[0] ? 16'h0002 : 16'h0003);
      d = tg[i] - ret_a[i];
      if (i[0]) begin
        run(pfbu_pkg::PFBU_OP_CALL_REL, 4'h0, pc[i], d[7:0], 8'h00);
        check(cyc, ce - 1);
      end else begin
        run(pfbu_pkg::PFBU_OP_CALL_EXT, 4'h0, pc[i], tg[i][15:8], tg[i][7:0]);
        ce = cyc;
      end
      check(o_next_pc, tg[i]);
      check(i_mem.mem[sp_e], ret_a[i][7:0]);
      check(i_mem.mem[sp_e - 16'h0001], ret_a[i][15:8]);
      sp_e = sp_e - 16'h0002;
      check(o_sp, sp_e);
    end
  endtask : t_calls

  task automatic t_trap;
    run(pfbu_pkg::PFBU_OP_TRAP, 4'h0, 16'h3000, 8'h00, 8'h00);
    check(o_next_pc, 16'h5ac3);
    check({i_mem.mem[sp_e - 16'h0001], i_mem.mem[sp_e]}, 16'h3001);
    check(i_mem.mem[sp_e - 16'h0006], i_regs.ccr);
    check(o_sp, sp_e - 16'h0007);
    run(pfbu_pkg::PFBU_OP_RET_INT, 4'h0, 16'h5ac3, 8'h00, 8'h00);
    check(o_next_pc, 16'h3001);
    check(got, i_regs);
    check(o_sp, sp_e);
  endtask : t_trap

  task automatic t_idle;
    int ws;
    i_regs <= {8'h0f, 8'h4b, 8'h5a, 16'h9876};
    ws = n_we;
    run(pfbu_pkg::PFBU_OP_IDLE, 4'h0, 16'h3100, 8'h00, 8'h00);
    check(w0 - ws, 7);
    check(n_we - w0, 0);
    check(o_next_pc, i_irq_vector);
    check(o_sp, sp_e - 16'h0007);
    run(pfbu_pkg::PFBU_OP_RET_INT, 4'h0, 16'h6000, 8'h00, 8'h00);
    check(o_next_pc, 16'h3101);
    check(got, i_regs);
    check(o_sp, sp_e);
  endtask : t_idle

  task automatic t_rets;
    for (int i = 3; i >= 0; i--) begin
      run(pfbu_pkg::PFBU_OP_RET_SUB, 4'h0, 16'h7000, 8'h00, 8'h00);
      check(o_next_pc, ret_a[i]);
      sp_e = sp_e + 16'h0002;
      check(o_sp, sp_e);
    end
  endtask : t_rets

  task automatic t_branches;
    logic t;
    for (int c = 0; c < 14; c++) begin
      for (int f = 0; f < 16; f++) begin
        i_flags <= f[3:0];
        t = cond(c[3:0], f[3:0]);
        run(pfbu_pkg::PFBU_OP_BCOND, c[3:0], 16'h5000, 8'h80, 8'h00);
        check(o_taken, t);
        check(o_next_pc, t ? 16'h4f82 : 16'h5002);
      end
    end
  endtask : t_branches

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_flags = '0;
    i_regs = {8'hc5, 8'hb2, 8'ha1, 16'h2000};
    i_irq = 1'b0;
    i_irq_vector = 16'h6000;
    sp_e = pfbu_pkg::PFBU_SP_RESET;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_jumps();
    t_calls();
    t_trap();
    t_idle();
    t_rets();
    t_branches();
    results();
  end
endmodule : pfbu_flow_test

bind pfbu_flow pfbu_flow_assertions i_chk (
  .i_clock, .i_rst_b, .i_ce, .i_req_valid, .i_req, .i_regs, .i_mem_rdata, .o_busy,
  .o_done, .o_next_pc, .o_taken, .o_mem_we, .o_mem_re, .o_mem_addr, .o_sp, .o_waiting
);
